// ### logic/rtp_pkg.sv
// rtp_pkg: constants, bus carrier and state record of the remote timer port block
// assumes ref_clk is the oscillator itself, so one cycle is 1/oscillator_frequency
package rtp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_KEY_SPECIAL_INPUT = 8'h00;
  localparam logic [7:0] OFS_TIMER_CARRIER_CONTROL = 8'h04;
  localparam logic [7:0] OFS_PORT_MODE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_TIMER = 8'h0C;
  localparam logic [7:0] OFS_HALT_WAIT = 8'h10;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TIMER_CARRIER_CONTROL = 8'h03;
  localparam logic [7:0] RST_PORT_MODE_CONTROL = 8'h26;
  localparam logic [7:0] WMASK_TIMER_CARRIER_CONTROL = 8'h3F;
  localparam logic [7:0] WMASK_PORT_MODE_CONTROL = 8'h37;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL0_CARRIER_SELECT_LO = 0;
  localparam int CTL0_CARRIER_SELECT_HI = 1;
  localparam int CTL0_CARRIER_GATE = 2;
  localparam int CTL0_DIVIDER_HALVING = 3;
  localparam int CTL0_ROM_POINTER_BIT_LO = 4;
  localparam int CTL0_ROM_POINTER_BIT_HI = 5;
  localparam int CTL1_AUX_A_MODE = 0;
  localparam int CTL1_KEY_SCAN_DIR = 1;
  localparam int CTL1_INDICATOR_MODE = 2;
  localparam int CTL1_AUX_PULLDOWN = 4;
  localparam int CTL1_KEY_PULLDOWN = 5;
  localparam int TMR_OUTPUT_ENABLE = 9;
  localparam int TMR_RUNNING = 10;
  localparam int TMR_END = 11;

  // ----------------------------------------------------------------
  // timing, in oscillator cycles, and synchroniser width
  // ----------------------------------------------------------------
  localparam int TIMER_CLOCK_DIV = 64;
  localparam int TIMER_CLOCK_DIV_HALVED = 128;
  localparam logic [7:0] CARRIER_PERIOD_FX8 = 8'h08;
  localparam logic [7:0] CARRIER_PERIOD_FX64 = 8'h40;
  localparam logic [7:0] CARRIER_PERIOD_FX96 = 8'h60;
  localparam int SYNC_W = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rtp_wb_req_t;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [8:0] tcount;
    logic out_en;
    logic running;
    logic tail;
    logic halt;
    logic [6:0] pre;
    logic [7:0] car;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    logic tx;
    logic led;
    logic ack;
    logic [31:0] dat;
  } rtp_state_t;

endpackage : rtp_pkg

// ### logic/rtp_top.sv
// rtp_top: remote transmission timer, carrier, key and special input ports
// assumes a classic wishbone master on ref_clk and raw pins from the board
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

module rtp_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire rtp_pkg::rtp_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] key_input_pins,
  output logic key_pulldown_en,
  output logic key_scan_dir_out,
  input wire logic aux_input_a,
  output logic aux_input_a_enable,
  output logic aux_input_a_pulldown_en,
  input wire logic aux_input_indicator_i,
  output logic aux_input_indicator_o,
  output logic aux_input_indicator_oe_n,
  output logic aux_input_indicator_pulldown_en,
  output logic remote_transmit_pin,
  output logic [1:0] rom_pointer_hi,
  output logic timer_end,
  output logic core_halt
);

  rtp_pkg::rtp_state_t r_reg;
  rtp_pkg::rtp_state_t r_next;

  // ----------------------------------------------------------------
  // decoded views of current state
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic ld;
  logic halving;
  logic tick;
  logic carrier;
  logic end_now;
  logic [6:0] pre_last;
  logic [7:0] car_period;
  logic [7:0] car_high;
  logic [7:0] kin_val;

  assign req = wb_req.cyc && wb_req.stb && !r_reg.ack;
  // writes land at the edge where the master samples ack
  assign wr = wb_req.cyc && wb_req.stb && r_reg.ack && wb_req.we && wb_req.sel[0];
  assign ld = wr && wb_req.sel[1] && (wb_req.adr == rtp_pkg::OFS_TIMER);
  assign halving = r_reg.ctl0[rtp_pkg::CTL0_DIVIDER_HALVING];

  assign pre_last = halving ? 7'(rtp_pkg::TIMER_CLOCK_DIV_HALVED - 1)
                            : 7'(rtp_pkg::TIMER_CLOCK_DIV - 1);
  assign tick = (r_reg.pre == pre_last);

  assign end_now = !r_reg.running && (r_reg.tcount == 9'h000);

  always_comb
  begin
    unique case (r_reg.ctl0[1:0])
      2'b00: car_period = rtp_pkg::CARRIER_PERIOD_FX8;
      2'b01: car_period = rtp_pkg::CARRIER_PERIOD_FX64;
      2'b10: car_period = rtp_pkg::CARRIER_PERIOD_FX96;
      2'b11: car_period = rtp_pkg::CARRIER_PERIOD_FX96;
    endcase
    if (halving)
    begin
      car_period = car_period << 1;
    end
    car_high = (r_reg.ctl0[1:0] == 2'b11) ? 8'(car_period / 8'h03) : (car_period >> 1);
  end

  assign carrier = (r_reg.car < car_high);

  // ----------------------------------------------------------------
  // key and special input register view
  // ----------------------------------------------------------------
  // keys, shared indicator pin, aux input A (one while its mode bit is off) and fixed ones
  assign kin_val = {r_reg.filt[3:0], r_reg.filt[5],
                    r_reg.ctl1[rtp_pkg::CTL1_AUX_A_MODE] ? r_reg.filt[4] : 1'b1, 2'b11};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    // pin synchroniser, change taken when second and third agree
    r_next.s1 = {aux_input_indicator_i, aux_input_a, key_input_pins};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3)
    begin
      r_next.filt = r_reg.s3;
    end

    // bus answer: one wait state, ack for one cycle
    r_next.ack = req;
    if (req && !wb_req.we)
    begin
      unique case (wb_req.adr)
        rtp_pkg::OFS_KEY_SPECIAL_INPUT: r_next.dat = {24'h00_0000, kin_val};
        rtp_pkg::OFS_TIMER_CARRIER_CONTROL: r_next.dat = {24'h00_0000, r_reg.ctl0};
        rtp_pkg::OFS_PORT_MODE_CONTROL: r_next.dat = {24'h00_0000, r_reg.ctl1};
        rtp_pkg::OFS_TIMER: r_next.dat = {20'h0_0000, end_now, r_reg.running, r_reg.out_en,
                                          r_reg.tcount};
        rtp_pkg::OFS_HALT_WAIT: r_next.dat = {31'h0000_0000, r_reg.halt};
        default: r_next.dat = 32'h0000_0000;
      endcase
    end

    // fixed-zero bits masked, read-only register absent
    if (wr && wb_req.adr == rtp_pkg::OFS_TIMER_CARRIER_CONTROL)
    begin
      r_next.ctl0 = wb_req.dat[7:0] & rtp_pkg::WMASK_TIMER_CARRIER_CONTROL;
    end
    if (wr && wb_req.adr == rtp_pkg::OFS_PORT_MODE_CONTROL)
    begin
      r_next.ctl1 = wb_req.dat[7:0] & rtp_pkg::WMASK_PORT_MODE_CONTROL;
    end

    // free-running carrier divider
    r_next.car = (r_reg.car >= car_period - 8'h01) ? 8'h00 : r_reg.car + 8'h01;

    r_next.pre = tick ? 7'h00 : r_reg.pre + 7'h01;
    if (ld)
    begin
      r_next.tcount = wb_req.dat[8:0];
      r_next.out_en = wb_req.dat[rtp_pkg::TMR_OUTPUT_ENABLE];
      r_next.running = (wb_req.dat[8:0] != 9'h000);
      r_next.pre = 7'h00;
    end
    else if (r_reg.running && tick)
    begin
      if (r_reg.tcount != 9'h000)
      begin
        r_next.tcount = r_reg.tcount - 9'h001;
      end
      else
      begin
        r_next.running = 1'b0;
      end
    end

    if (wr && wb_req.adr == rtp_pkg::OFS_HALT_WAIT)
    begin
      r_next.halt = wb_req.dat[0];
    end
    if (end_now)
    begin
      r_next.halt = 1'b0;
    end

    r_next.tail = !r_reg.ctl0[rtp_pkg::CTL0_CARRIER_GATE] && carrier
                  && (r_reg.running || r_reg.tail);

    if (r_reg.running)
    begin
      r_next.tx = r_reg.out_en && (r_reg.ctl0[rtp_pkg::CTL0_CARRIER_GATE] || carrier);
    end
    else
    begin
      r_next.tx = r_reg.out_en && r_reg.tail && carrier;
    end
    r_next.led = !(r_reg.out_en && r_reg.running);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      r_reg <= '0;
      r_reg.ctl0 <= rtp_pkg::RST_TIMER_CARRIER_CONTROL;
      r_reg.ctl1 <= rtp_pkg::RST_PORT_MODE_CONTROL;
      r_reg.led <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign key_pulldown_en = r_reg.ctl1[rtp_pkg::CTL1_KEY_PULLDOWN];
  assign key_scan_dir_out = r_reg.ctl1[rtp_pkg::CTL1_KEY_SCAN_DIR];
  assign aux_input_a_enable = r_reg.ctl1[rtp_pkg::CTL1_AUX_A_MODE];
  assign aux_input_a_pulldown_en = r_reg.ctl1[rtp_pkg::CTL1_AUX_PULLDOWN]
                                   && r_reg.ctl1[rtp_pkg::CTL1_AUX_A_MODE];
  assign aux_input_indicator_pulldown_en = r_reg.ctl1[rtp_pkg::CTL1_AUX_PULLDOWN]
                                           && !r_reg.ctl1[rtp_pkg::CTL1_INDICATOR_MODE];
  assign aux_input_indicator_oe_n = !r_reg.ctl1[rtp_pkg::CTL1_INDICATOR_MODE];
  assign aux_input_indicator_o = r_reg.led;
  assign remote_transmit_pin = r_reg.tx;
  assign rom_pointer_hi = r_reg.ctl0[rtp_pkg::CTL0_ROM_POINTER_BIT_HI:
                                     rtp_pkg::CTL0_ROM_POINTER_BIT_LO];
  assign timer_end = end_now;
  assign core_halt = r_reg.halt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ctl1_fixed;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.ctl1[7:6] == 2'b00) && !r_reg.ctl1[3];
  endproperty
  a_ctl1_fixed: assert property (p_ctl1_fixed) else $error("control 1 fixed bit set");

  property p_ctl0_fixed;
    @(posedge ref_clk) disable iff (reset)
    wr |=> (r_reg.ctl0[7:6] == 2'b00);
  endproperty
  a_ctl0_fixed: assert property (p_ctl0_fixed) else $error("control 0 fixed bit set");

  property p_key_view;
    @(posedge ref_clk) disable iff (reset)
    (kin_val[1:0] == 2'b11) && (kin_val[7:4] == r_reg.filt[3:0]);
  endproperty
  a_key_view: assert property (p_key_view) else $error("key view wrong");

  property p_aux_off_one;
    @(posedge ref_clk) disable iff (reset)
    !aux_input_a_enable |-> kin_val[2];
  endproperty
  a_aux_off_one: assert property (p_aux_off_one) else $error("off mode bit not one");

  property p_start;
    @(posedge ref_clk) disable iff (reset)
    (ld && wb_req.dat[8:0] != 9'h000) |=> r_reg.running ##1 r_reg.running;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start");

  property p_stop_end;
    @(posedge ref_clk) disable iff (reset)
    $fell(r_reg.running) && !$past(ld) |-> timer_end && (r_reg.tcount == 9'h000);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop without end");

  property p_tick_space;
    @(posedge ref_clk) disable iff (reset)
    (tick && !halving && !ld) |=> !tick [*8];
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("timer clock too fast");

  property p_led_low;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.out_en && r_reg.running) |=> !aux_input_indicator_o;
  endproperty
  a_led_low: assert property (p_led_low) else $error("indicator not low");

  property p_pulldown_off;
    @(posedge ref_clk) disable iff (reset)
    !aux_input_indicator_oe_n |-> !aux_input_indicator_pulldown_en;
  endproperty
  a_pulldown_off: assert property (p_pulldown_off) else $error("pull-down on output");

  property p_halt_release;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.halt && end_now) |=> !core_halt;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");

  property p_count_hold;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.running && !tick && !ld) |=> $stable(r_reg.tcount);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved off tick");

  property p_count_step;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.running && tick && !ld && (r_reg.tcount != 9'h000))
      |=> (r_reg.tcount == $past(r_reg.tcount) - 9'h001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_gate_high;
    @(posedge ref_clk) disable iff (reset)
    (r_reg.running && r_reg.out_en && r_reg.ctl0[rtp_pkg::CTL0_CARRIER_GATE])
      |=> remote_transmit_pin;
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("transmit not steady high");

  property p_tx_low;
    @(posedge ref_clk) disable iff (reset)
    (!r_reg.running && !r_reg.tail) |=> !remote_transmit_pin;
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("transmit high while stopped");

  property p_tail_on;
    @(posedge ref_clk) disable iff (reset)
    (!r_reg.running && r_reg.tail && carrier && r_reg.out_en) |=> remote_transmit_pin;
  endproperty
  a_tail_on: assert property (p_tail_on) else $error("carrier tail cut short");

  property p_aux_pd_off;
    @(posedge ref_clk) disable iff (reset)
    !aux_input_a_enable |-> !aux_input_a_pulldown_en;
  endproperty
  a_aux_pd_off: assert property (p_aux_pd_off) else $error("pull-down on off pin");

endmodule : rtp_top

// ### verif/rtp_far_side.sv
// rtp_far_side: key matrix switches, special inputs and shared pin wire
// assumes the bench sets switch levels; the shared wire resolves both drivers
`timescale 1ns/1ps

module rtp_far_side (
  input wire logic [3:0] press,
  input wire logic aux_level,
  input wire logic shared_level,
  input wire logic shared_o,
  input wire logic shared_oe_n,
  output logic [3:0] key_input_pins,
  output logic aux_input_a,
  output logic shared_wire
);
  // ----------------------------------------------------------------
  // switch levels
  // ----------------------------------------------------------------
  assign key_input_pins = press;
  assign aux_input_a = aux_level;
  // shared pin: block drives while oe_n low, else the switch
  assign shared_wire = shared_oe_n ? shared_level : shared_o;
endmodule : rtp_far_side

// ### verif/testbench.sv
// testbench: self-checking bench of the remote timer port block
// assumes rtp_top, the far side model and a 100 MHz ref_clk
`timescale 1ns/1ps

module testbench;
  logic ref_clk;
  logic reset;
  rtp_pkg::rtp_wb_req_t wb_req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] keys;
  logic key_pd;
  logic scan_dir;
  logic aux_a;
  logic aux_en;
  logic aux_pd;
  logic sh_i;
  logic sh_o;
  logic sh_oe_n;
  logic sh_pd;
  logic tx_pin;
  logic [1:0] rom_hi;
  logic tend;
  logic halt;
  logic [3:0] press;
  logic aux_lvl;
  logic sh_lvl;
  logic [31:0] q;
  int num_errors;
  int compares;
  int cycles;

  rtp_top u_dut (.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .key_input_pins(keys), .key_pulldown_en(key_pd),
    .key_scan_dir_out(scan_dir), .aux_input_a(aux_a), .aux_input_a_enable(aux_en),
    .aux_input_a_pulldown_en(aux_pd), .aux_input_indicator_i(sh_i),
    .aux_input_indicator_o(sh_o), .aux_input_indicator_oe_n(sh_oe_n),
    .aux_input_indicator_pulldown_en(sh_pd), .remote_transmit_pin(tx_pin),
    .rom_pointer_hi(rom_hi), .timer_end(tend), .core_halt(halt));

  rtp_far_side u_far (.press(press), .aux_level(aux_lvl), .shared_level(sh_lvl),
    .shared_o(sh_o), .shared_oe_n(sh_oe_n), .key_input_pins(keys), .aux_input_a(aux_a),
    .shared_wire(sh_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task tick;
    @(posedge ref_clk);
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_req <= {1'b1, 1'b1, we, a, 4'b0011, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1)
      @(posedge ref_clk);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask : wb

  // which 0 waits on the transmit pin, 1 on the end signal
  task automatic wait_for(input int which, input logic v);
    while (((which == 0) ? tx_pin : tend) !== v)
      tick;
  endtask : wait_for

  task automatic high_len(output int len);
    len = 0;
    while (tx_pin === 1'b1)
    begin
      len++;
      if (len == 10)
        chk({tend, sh_o}, 32'h0000_0000);
      tick;
    end
  endtask : high_len

  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({key_pd, sh_oe_n, sh_o, tend, aux_en, scan_dir}, 32'h0000_002D);
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk(q, 32'h0000_0026);
    $display("reset test done");
  endtask : t_reset

  task t_regs;
    wb(1'b1, 8'h08, 32'h0000_00FF);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk(q, 32'h0000_0037);
    chk({key_pd, scan_dir, aux_en, aux_pd, sh_pd, sh_oe_n}, 32'h0000_003C);
    wb(1'b1, 8'h08, 32'h0000_0010);
    chk({key_pd, scan_dir, aux_en, aux_pd, sh_pd, sh_oe_n}, 32'h0000_0003);
    wb(1'b1, 8'h04, 32'h0000_00FF);
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(q, 32'h0000_003F);
    chk(rom_hi, 32'h0000_0003);
    wb(1'b1, 8'h04, 32'h0000_0010);
    chk(rom_hi, 32'h0000_0001);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("register test done");
  endtask : t_regs

  task t_inputs;
    wb(1'b1, 8'h08, 32'h0000_0011);
    press <= 4'hA;
    aux_lvl <= 1'b0;
    sh_lvl <= 1'b0;
    repeat (8) tick;
    wb(1'b1, 8'h00, 32'h0000_0000);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_00A3);
    aux_lvl <= 1'b1;
    sh_lvl <= 1'b1;
    repeat (8) tick;
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_00AF);
    wb(1'b1, 8'h08, 32'h0000_0004);
    aux_lvl <= 1'b0;
    sh_lvl <= 1'b0;
    press <= 4'h5;
    repeat (8) tick;
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_005F);
    $display("input test done");
  endtask : t_inputs

  task automatic t_timer;
    int len;
    wb(1'b1, 8'h04, 32'h0000_0004);
    wb(1'b1, 8'h0C, 32'h0000_0203);
    wait_for(0, 1'b1);
    high_len(len);
    chk(len, 32'h0000_0100);
    chk({tend, sh_o, tx_pin}, 32'h0000_0006);
    wb(1'b1, 8'h04, 32'h0000_000C);
    wb(1'b1, 8'h0C, 32'h0000_0203);
    wait_for(0, 1'b1);
    high_len(len);
    chk(len, 32'h0000_0200);
    wb(1'b1, 8'h0C, 32'h0000_0200);
    repeat (4) tick;
    chk({tend, tx_pin}, 32'h0000_0002);
    $display("timer test done");
  endtask : t_timer

  task automatic t_carrier;
    logic [7:0] ctl [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
    int exp_hi [5] = '{4, 32, 48, 32, 8};
    int len;
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, 8'h04, {24'h00_0000, ctl[i]});
      wb(1'b1, 8'h0C, 32'h0000_0207);
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      wait_for(0, 1'b1);
      high_len(len);
      chk(len, exp_hi[i]);
      wait_for(1, 1'b1);
      // after stop the carrier may only finish its current high phase
      len = 0;
      while (tx_pin === 1'b1)
      begin
        len++;
        tick;
      end
      chk(len <= exp_hi[i], 32'h0000_0001);
      repeat (20) tick;
      chk(tx_pin, 32'h0000_0000);
    end
    $display("carrier test done");
  endtask : t_carrier

  task t_halt;
    wb(1'b1, 8'h04, 32'h0000_0004);
    wb(1'b1, 8'h0C, 32'h0000_0201);
    wb(1'b1, 8'h10, 32'h0000_0001);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk({halt, q[0]}, 32'h0000_0003);
    wait_for(1, 1'b1);
    repeat (2) tick;
    chk(halt, 32'h0000_0000);
    $display("halt test done");
  endtask : t_halt

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      num_errors++;
      end_of_test;
    end
  end

  initial
  begin
    reset = 1'b1;
    wb_req = '0;
    press = 4'h0;
    aux_lvl = 1'b0;
    sh_lvl = 1'b0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    tick;
    t_reset;
    t_regs;
    t_inputs;
    t_timer;
    t_carrier;
    t_halt;
    end_of_test;
  end
endmodule : testbench
